// [design/rsc_scan_control.sv]
`timescale 1ns/1ps
module rsc_scan_control #(
   parameter int NUM_MOD = rsc_pkg::NUM_MOD,
   parameter int RELAYS = rsc_pkg::RELAYS,
   parameter int SCAN_DEPTH = rsc_pkg::SCAN_DEPTH,
   parameter int TTL_LINES = rsc_pkg::TTL_LINES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_op,
   input wire logic [rsc_pkg::NAME_W-1:0] cmd_name,
   input wire logic [3*rsc_pkg::FIELD_W-1:0] cmd_first,
   input wire logic [3*rsc_pkg::FIELD_W-1:0] cmd_last,
   input wire logic cmd_range,
   input wire logic [1:0] cmd_source,
   input wire logic [$clog2(TTL_LINES)-1:0] cmd_ttl_line,
   input wire logic [$clog2(NUM_MOD)-1:0] cmd_define_mod,
   input wire logic [rsc_pkg::DELAY_W-1:0] trigger_delay,
   input wire logic [TTL_LINES-1:0] backplane_ttl_trigger,
   output logic cmd_ready,
   output logic [NUM_MOD*RELAYS-1:0] relay_closed,
   output logic resp_valid,
   output logic resp_bit,
   output logic cmd_error,
   output logic scan_armed
);
   localparam int MOD_W = $clog2(NUM_MOD);
   localparam int REL_W = $clog2(RELAYS);
   localparam int SCAN_W = $clog2(SCAN_DEPTH + 1);
   localparam int TTL_W = $clog2(TTL_LINES);
   localparam int ENT_W = MOD_W + REL_W;

   initial begin
      if (NUM_MOD < 2 || NUM_MOD > 9 || RELAYS < 2 || SCAN_DEPTH < 2 || TTL_LINES < 2 ||
          RELAYS > rsc_pkg::DIM1 * rsc_pkg::DIM2 * rsc_pkg::DIM3 || (RELAYS & (RELAYS - 1)) != 0) begin
         $error("rsc_scan_control: unsupported parameter values");
      end
   end

   typedef struct packed {
      rsc_pkg::rsc_mode_type mode;
      rsc_pkg::rsc_src_type src;
      logic [TTL_W-1:0] ttl_sel;
      logic [TTL_LINES-1:0] ttl_prev;
      logic pending;
      logic [rsc_pkg::DELAY_W-1:0] delay_cnt;
      logic [SCAN_W-1:0] idx;
      logic [SCAN_W-1:0] len;
      logic prev_valid;
      logic [ENT_W-1:0] prev;
      logic [SCAN_DEPTH-1:0][ENT_W-1:0] scan;
      logic [NUM_MOD-1:0][RELAYS-1:0] relay;
      logic busy;
      logic [MOD_W-1:0] q_mod;
      logic [REL_W-1:0] q_cur;
      logic [REL_W-1:0] q_end;
      logic resp_valid;
      logic resp_bit;
      logic err;
      logic ready;
   } rsc_state_type;

   rsc_state_type r;
   rsc_state_type next_r;
   rsc_name_if #(.MOD_W(MOD_W)) nif ();

   // Unused trailing fields are zero; numbers start at 1
   function automatic logic [REL_W-1:0] flatten(input logic [3*rsc_pkg::FIELD_W-1:0] a);
      logic [15:0] f1;
      logic [15:0] f2;
      logic [15:0] f3;
      logic [15:0] flat;
      f1 = (a[3*rsc_pkg::FIELD_W-1 -: rsc_pkg::FIELD_W] == 0) ? 16'h0 :
           16'(a[3*rsc_pkg::FIELD_W-1 -: rsc_pkg::FIELD_W]) - 16'h1;
      f2 = (a[2*rsc_pkg::FIELD_W-1 -: rsc_pkg::FIELD_W] == 0) ? 16'h0 :
           16'(a[2*rsc_pkg::FIELD_W-1 -: rsc_pkg::FIELD_W]) - 16'h1;
      f3 = (a[rsc_pkg::FIELD_W-1:0] == 0) ? 16'h0 : 16'(a[rsc_pkg::FIELD_W-1:0]) - 16'h1;
      flat = f1 + 16'(f2 * rsc_pkg::DIM1) + 16'(f3 * rsc_pkg::DIM1 * rsc_pkg::DIM2);
      return flat[REL_W-1:0];
   endfunction : flatten

   rsc_name_table #(.NUM_MOD(NUM_MOD)) u_names (
      .clk(clk),
      .reset(reset),
      .nif(nif.table_side)
   );

   logic [REL_W-1:0] first_f;
   logic [REL_W-1:0] last_f;
   logic take;
   logic ttl_edge;
   logic accept;
   logic force_now;
   logic step;
   logic [ENT_W-1:0] ent;

   always_comb begin
      next_r = r;
      next_r.resp_valid = 1'b0;
      next_r.err = 1'b0;
      next_r.ttl_prev = backplane_ttl_trigger;
      first_f = flatten(cmd_first);
      last_f = cmd_range ? flatten(cmd_last) : first_f;
      take = cmd_valid && !r.busy;
      nif.look_name = cmd_name;
      nif.def_en = take && cmd_op == rsc_pkg::RSC_OP_DEFINE;
      nif.def_name = cmd_name;
      nif.def_mod = cmd_define_mod;
      ttl_edge = backplane_ttl_trigger[r.ttl_sel] && !r.ttl_prev[r.ttl_sel];
      // Hold matches no source, so only a forced trigger or a trigger already pending before the switch steps
      accept = r.mode == rsc_pkg::RSC_ARMED && !r.pending &&
               ((r.src == rsc_pkg::RSC_SRC_BUS && take && cmd_op == rsc_pkg::RSC_OP_TRIG_BUS) ||
                (r.src == rsc_pkg::RSC_SRC_TTL && ttl_edge) ||
                (r.src == rsc_pkg::RSC_SRC_IMM));
      force_now = r.mode == rsc_pkg::RSC_ARMED && take && cmd_op == rsc_pkg::RSC_OP_TRIG_FORCE;
      step = force_now || (r.pending && r.delay_cnt == 0) || (accept && trigger_delay == 0);
      ent = r.scan[r.idx[$clog2(SCAN_DEPTH)-1:0]];
      if (step) begin
         if (r.prev_valid) begin
            next_r.relay[r.prev[ENT_W-1 -: MOD_W]][r.prev[REL_W-1:0]] = 1'b0;
         end
         next_r.relay[ent[ENT_W-1 -: MOD_W]][ent[REL_W-1:0]] = 1'b1;
         next_r.prev = ent;
         next_r.prev_valid = 1'b1;
         next_r.pending = 1'b0;
         if (r.idx == r.len - SCAN_W'(1)) begin
            next_r.mode = rsc_pkg::RSC_IDLE;
            next_r.idx = '0;
         end else begin
            next_r.idx = r.idx + SCAN_W'(1);
         end
      end else if (accept) begin
         next_r.pending = 1'b1;
         next_r.delay_cnt = trigger_delay - rsc_pkg::DELAY_W'(1);
      end else if (r.pending) begin
         next_r.delay_cnt = r.delay_cnt - rsc_pkg::DELAY_W'(1);
      end
      if (r.busy) begin
         next_r.resp_valid = 1'b1;
         next_r.resp_bit = r.relay[r.q_mod][r.q_cur];
         if (r.q_cur == r.q_end) begin
            next_r.busy = 1'b0;
         end else begin
            next_r.q_cur = r.q_cur + REL_W'(1);
         end
      end else if (take) begin
         case (cmd_op)
            rsc_pkg::RSC_OP_ABORT: begin
               next_r.mode = rsc_pkg::RSC_IDLE;
               next_r.pending = 1'b0;
            end
            rsc_pkg::RSC_OP_ARM: begin
               if (r.len == 0) begin
                  next_r.err = 1'b1;
               end else begin
                  next_r.mode = rsc_pkg::RSC_ARMED;
                  next_r.idx = '0;
                  next_r.pending = 1'b0;
               end
            end
            rsc_pkg::RSC_OP_SET_SOURCE: begin
               next_r.src = rsc_pkg::rsc_src_type'(cmd_source);
               next_r.ttl_sel = cmd_ttl_line;
            end
            rsc_pkg::RSC_OP_CLOSE, rsc_pkg::RSC_OP_CLOSE_QUERY: begin
               if (!nif.look_hit || last_f < first_f) begin
                  next_r.err = 1'b1;
               end else if (cmd_op == rsc_pkg::RSC_OP_CLOSE) begin
                  for (int i = 0; i < RELAYS; i++) begin
                     if (REL_W'(i) >= first_f && REL_W'(i) <= last_f) begin
                        next_r.relay[nif.look_mod][i] = 1'b1;
                     end
                  end
               end else begin
                  next_r.busy = 1'b1;
                  next_r.q_mod = nif.look_mod;
                  next_r.q_cur = first_f;
                  next_r.q_end = last_f;
               end
            end
            rsc_pkg::RSC_OP_RESET: begin
               next_r.relay = '0;
               next_r.prev_valid = 1'b0;
               next_r.mode = rsc_pkg::RSC_IDLE;
               next_r.pending = 1'b0;
            end
            rsc_pkg::RSC_OP_SCAN_CLEAR: begin
               next_r.len = '0;
               next_r.idx = '0;
               next_r.mode = rsc_pkg::RSC_IDLE;
               next_r.pending = 1'b0;
            end
            rsc_pkg::RSC_OP_SCAN_ADD: begin
               if (!nif.look_hit || r.len == SCAN_W'(SCAN_DEPTH)) begin
                  next_r.err = 1'b1;
               end else begin
                  next_r.scan[r.len[$clog2(SCAN_DEPTH)-1:0]] = {nif.look_mod, first_f};
                  next_r.len = r.len + SCAN_W'(1);
               end
            end
            default: begin
            end
         endcase
      end
      // Ready follows the state it will see, so a query blocks the very next edge
      next_r.ready = !next_r.busy;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
         r.mode <= rsc_pkg::RSC_IDLE;
         r.src <= rsc_pkg::SRC_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign cmd_ready = r.ready;
   assign relay_closed = r.relay;
   assign resp_valid = r.resp_valid;
   assign resp_bit = r.resp_bit;
   assign cmd_error = r.err;
   assign scan_armed = r.mode == rsc_pkg::RSC_ARMED;
endmodule : rsc_scan_control

// [design/rsc_pkg.sv]
// Operation
// - Abort returns an initiated scan to idle.
// - After abort, triggers ignored until re-armed.
// - Hold source blocks TTL, bus, immediate triggers.
// - Forced trigger steps despite hold, skipping delay.
// - First accepted trigger closes first scan entry.
// - Later triggers open previous, close next entry.
// - Close command closes every relay listed.
// - Close query answers 1 closed, 0 open.
// - Reset command opens every relay everywhere.
// - Range is one relay or inclusive span.
// - Relay numbers have one to three fields.
// - Three fields mean row, column, section.
// - Module names resolve through defined associations.
// - Default names m1, m2, ... by slot.
// - Trigger source: bus, hold, immediate, TTL line.
// - Arm command enables triggers for stepping.
package rsc_pkg;
   localparam int NUM_MOD = 4;
   localparam int RELAYS = 64;
   localparam int SCAN_DEPTH = 16;
   localparam int TTL_LINES = 8;
   localparam int NAME_W = 16;
   localparam int FIELD_W = 4;
   localparam int DELAY_W = 16;
   localparam int DIM1 = 4;
   localparam int DIM2 = 4;
   localparam int DIM3 = 4;
   localparam logic [7:0] NAME_LETTER = 8'h6d;
   localparam logic [7:0] NAME_DIGIT0 = 8'h31;

   typedef enum logic [3:0] {
      RSC_OP_ABORT = 4'h0,
      RSC_OP_ARM = 4'h1,
      RSC_OP_TRIG_BUS = 4'h2,
      RSC_OP_TRIG_FORCE = 4'h3,
      RSC_OP_SET_SOURCE = 4'h4,
      RSC_OP_CLOSE = 4'h5,
      RSC_OP_CLOSE_QUERY = 4'h6,
      RSC_OP_RESET = 4'h7,
      RSC_OP_DEFINE = 4'h8,
      RSC_OP_SCAN_CLEAR = 4'h9,
      RSC_OP_SCAN_ADD = 4'ha
   } rsc_op_type;

   typedef enum logic [1:0] {
      RSC_SRC_BUS = 2'h0,
      RSC_SRC_HOLD = 2'h1,
      RSC_SRC_IMM = 2'h2,
      RSC_SRC_TTL = 2'h3
   } rsc_src_type;

   typedef enum logic [0:0] {
      RSC_IDLE = 1'h0,
      RSC_ARMED = 1'h1
   } rsc_mode_type;

   localparam rsc_src_type SRC_RESET = RSC_SRC_IMM;
endpackage : rsc_pkg

// [design/rsc_name_if.sv]
`timescale 1ns/1ps
interface rsc_name_if #(parameter int MOD_W = 2);
   logic [rsc_pkg::NAME_W-1:0] look_name;
   logic look_hit;
   logic [MOD_W-1:0] look_mod;
   logic def_en;
   logic [rsc_pkg::NAME_W-1:0] def_name;
   logic [MOD_W-1:0] def_mod;
   modport user (output look_name, input look_hit, input look_mod, output def_en, output def_name, output def_mod);
   modport table_side (input look_name, output look_hit, output look_mod, input def_en, input def_name, input def_mod);
endinterface : rsc_name_if

// [design/rsc_name_table.sv]
`timescale 1ns/1ps
module rsc_name_table #(
   parameter int NUM_MOD = rsc_pkg::NUM_MOD
) (
   input wire logic clk,
   input wire logic reset,
   rsc_name_if.table_side nif
);
   typedef struct packed {
      logic [NUM_MOD-1:0][rsc_pkg::NAME_W-1:0] name;
   } rsc_names_type;

   rsc_names_type r;
   rsc_names_type next_r;

   // Lowest slot wins when two modules share a name
   always_comb begin
      next_r = r;
      nif.look_hit = 1'b0;
      nif.look_mod = '0;
      for (int i = NUM_MOD - 1; i >= 0; i--) begin
         if (r.name[i] == nif.look_name) begin
            nif.look_hit = 1'b1;
            nif.look_mod = i[$bits(nif.look_mod)-1:0];
         end
      end
      if (nif.def_en) begin
         next_r.name[nif.def_mod] = nif.def_name;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_MOD; i++) begin
            r.name[i] <= {rsc_pkg::NAME_LETTER, rsc_pkg::NAME_DIGIT0 + 8'(i)};
         end
      end else begin
         r <= next_r;
      end
   end
endmodule : rsc_name_table

// [tb/rsc_chk.sv]
`timescale 1ns/1ps
module rsc_chk #(parameter int NUM_MOD = 4, parameter int RELAYS = 64) (
   input wire logic clk,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_op,
   input wire logic [15:0] cmd_name,
   input wire logic [11:0] cmd_first,
   input wire logic cmd_range,
   input wire logic cmd_ready,
   input wire logic [NUM_MOD*RELAYS-1:0] relay_closed,
   input wire logic resp_valid,
   input wire logic cmd_error,
   input wire logic scan_armed
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic tk;
   assign tk = cmd_valid && cmd_ready;
   property p_abort; tk && cmd_op == 4'h0 |=> !scan_armed; endproperty
   a_abort: assert property (p_abort) else $error("abort left scan armed");
   property p_arm_only; $rose(scan_armed) |-> $past(tk && cmd_op == 4'h1); endproperty
   a_arm_only: assert property (p_arm_only) else $error("armed without arm command");
   property p_idle_still; !scan_armed && !cmd_valid |=> $stable(relay_closed); endproperty
   a_idle_still: assert property (p_idle_still) else $error("relays moved while idle");
   property p_arm; tk && cmd_op == 4'h1 |=> scan_armed || cmd_error; endproperty
   a_arm: assert property (p_arm) else $error("arm command not armed");
   property p_force; tk && cmd_op == 4'h3 && scan_armed |=> relay_closed != $past(relay_closed); endproperty
   a_force: assert property (p_force) else $error("forced trigger did not step at once");
   property p_reset_cmd; tk && cmd_op == 4'h7 |=> relay_closed == '0; endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command left relays closed");
   property p_query; tk && cmd_op == 4'h6 |=> (cmd_error ##1 1'b1) or (!cmd_ready ##1 resp_valid); endproperty
   a_query: assert property (p_query) else $error("query answer late");
   property p_close_one;
      tk && cmd_op == 4'h5 && !cmd_range && cmd_name == 16'h6d31 && cmd_first == 12'h100
         |=> relay_closed[0] || cmd_error;
   endproperty
   a_close_one: assert property (p_close_one) else $error("close missed relay");
   c_query: cover property (tk && cmd_op == 4'h6);
   c_force: cover property (tk && cmd_op == 4'h3 && scan_armed);
   c_idle: cover property ($fell(scan_armed));
endmodule : rsc_chk
bind rsc_scan_control rsc_chk #(.NUM_MOD(NUM_MOD), .RELAYS(RELAYS)) chk (.clk(clk), .reset(reset),
   .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_name(cmd_name), .cmd_first(cmd_first), .cmd_range(cmd_range),
   .cmd_ready(cmd_ready), .relay_closed(relay_closed), .resp_valid(resp_valid), .cmd_error(cmd_error),
   .scan_armed(scan_armed));

// [tb/rsc_host.sv]
`timescale 1ns/1ps
module rsc_host (
   input wire logic clk,
   input wire logic cmd_ready,
   output logic cmd_valid,
   output logic [3:0] cmd_op,
   output logic [15:0] cmd_name,
   output logic [11:0] cmd_first,
   output logic [11:0] cmd_last,
   output logic cmd_range,
   output logic [1:0] cmd_source,
   output logic [2:0] cmd_ttl_line,
   output logic [1:0] cmd_define_mod,
   output logic [15:0] trigger_delay,
   output logic [7:0] backplane_ttl_trigger
);
   initial begin
      {cmd_valid, cmd_op, cmd_name, cmd_first, cmd_last, cmd_range, cmd_source} = '0;
      {cmd_define_mod, trigger_delay, backplane_ttl_trigger} = '0;
      cmd_ttl_line = 3'h2;
   end
   // Numbers as {row,column,section}, a zero field is absent; nonzero l means colon range
   task automatic send(input logic [3:0] op, input logic [15:0] nm, input logic [11:0] f, input logic [11:0] l,
                       input logic [1:0] aux);
      @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_op <= op;
      cmd_name <= nm;
      cmd_first <= f;
      cmd_last <= l;
      cmd_range <= (l != 12'h0);
      cmd_source <= aux;
      cmd_define_mod <= aux;
      // A stuck ready is caught by the bench's cycle ceiling
      do begin
         @(posedge clk);
      end while (cmd_ready !== 1'h1);
      cmd_valid <= 1'h0;
      // Stale name and first fields scrambled so nothing relies on them after release
      cmd_name <= ~nm;
      cmd_first <= ~f;
   endtask : send
   task automatic pulse();
      @(posedge clk);
      backplane_ttl_trigger <= 8'h04;
      @(posedge clk);
      backplane_ttl_trigger <= 8'h00;
   endtask : pulse
endmodule : rsc_host

// [tb/relay_scan_command_control_tb.sv]
`timescale 1ns/1ps
module relay_scan_command_control_tb;
   logic clk, reset, cmd_valid, cmd_range, cmd_ready, resp_valid, resp_bit, cmd_error, scan_armed;
   logic [3:0] cmd_op;
   logic [15:0] cmd_name, trigger_delay;
   logic [11:0] cmd_first, cmd_last;
   logic [1:0] cmd_source, cmd_define_mod;
   logic [2:0] cmd_ttl_line;
   logic [7:0] ttl;
   logic [255:0] rc, exp;
   logic [3:0] q;
   int miscompares, total_checks, cycles, n;
   rsc_host host (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_name(cmd_name),
      .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_range(cmd_range), .cmd_source(cmd_source),
      .cmd_ttl_line(cmd_ttl_line), .cmd_define_mod(cmd_define_mod), .trigger_delay(trigger_delay),
      .backplane_ttl_trigger(ttl));
   rsc_scan_control dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_name(cmd_name),
      .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_range(cmd_range), .cmd_source(cmd_source),
      .cmd_ttl_line(cmd_ttl_line), .cmd_define_mod(cmd_define_mod), .trigger_delay(trigger_delay),
      .backplane_ttl_trigger(ttl), .cmd_ready(cmd_ready), .relay_closed(rc), .resp_valid(resp_valid),
      .resp_bit(resp_bit), .cmd_error(cmd_error), .scan_armed(scan_armed));
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   task automatic check(input string what, input logic [255:0] seen, input logic [255:0] want);
      total_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   task automatic results();
      if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results
   task automatic wait_clk(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : wait_clk
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      reset = 1'h1;
      repeat (8) @(posedge clk);
      reset <= 1'h0;
      wait_clk(2);
      check("reset relays", rc, '0);
      host.send(4'h5, 16'h6d31, 12'h100, 12'h0, 2'h0);
      #1;
      check("close single", rc[1:0], 2'h1);
      host.send(4'h5, 16'h6d31, 12'h100, 12'h200, 2'h0);
      host.send(4'h5, 16'h6d32, 12'h324, 12'h0, 2'h0);
      host.send(4'h8, 16'h7266, 12'h0, 12'h0, 2'h2);
      host.send(4'h5, 16'h7266, 12'h100, 12'h0, 2'h0);
      #1;
      exp = '0;
      exp[1:0] = 2'h3;
      exp[118] = 1'h1;
      exp[128] = 1'h1;
      check("close", rc, exp);
      host.send(4'h6, 16'h6d31, 12'h100, 12'h400, 2'h0);
      #1;
      check("busy", cmd_ready, 1'h0);
      q = '0;
      n = 0;
      repeat (12) begin
         @(posedge clk);
         #1;
         if (resp_valid === 1'h1) begin
            q = {q[2:0], resp_bit};
            n++;
         end
      end
      check("query", {n, q}, {32'd4, 4'hc});
      check("ready again", cmd_ready, 1'h1);
      host.send(4'h5, 16'h7a7a, 12'h100, 12'h0, 2'h0);
      #1;
      check("unknown name", cmd_error, 1'h1);
      host.send(4'h7, 16'h0, 12'h0, 12'h0, 2'h0);
      #1;
      check("reset cmd", rc, '0);
      host.send(4'h9, 16'h0, 12'h0, 12'h0, 2'h0);
      for (int i = 1; i < 4; i++) host.send(4'ha, 16'h6d31, {i[3:0], 8'h00}, 12'h0, 2'h0);
      host.send(4'h4, 16'h0, 12'h0, 12'h0, 2'h1);
      host.trigger_delay <= 16'h0014;
      host.send(4'h1, 16'h0, 12'h0, 12'h0, 2'h0);
      #1;
      check("armed", scan_armed, 1'h1);
      host.send(4'h2, 16'h0, 12'h0, 12'h0, 2'h0);
      host.pulse();
      wait_clk(25);
      check("hold", rc[2:0], 3'h0);
      host.send(4'h3, 16'h0, 12'h0, 12'h0, 2'h0);
      #1;
      check("first step", rc[2:0], 3'h1);
      host.send(4'h3, 16'h0, 12'h0, 12'h0, 2'h0);
      #1;
      check("second step", rc[2:0], 3'h2);
      host.send(4'h0, 16'h0, 12'h0, 12'h0, 2'h0);
      #1;
      check("abort", scan_armed, 1'h0);
      host.send(4'h3, 16'h0, 12'h0, 12'h0, 2'h0);
      host.send(4'h2, 16'h0, 12'h0, 12'h0, 2'h0);
      wait_clk(25);
      check("after abort", rc[2:0], 3'h2);
      host.trigger_delay <= 16'h0000;
      host.send(4'h4, 16'h0, 12'h0, 12'h0, 2'h0);
      host.send(4'h1, 16'h0, 12'h0, 12'h0, 2'h0);
      host.send(4'h2, 16'h0, 12'h0, 12'h0, 2'h0);
      wait_clk(2);
      check("rearm first", rc[2:0], 3'h1);
      host.send(4'h4, 16'h0, 12'h0, 12'h0, 2'h3);
      host.pulse();
      wait_clk(3);
      check("ttl step", rc[2:0], 3'h2);
      host.send(4'h4, 16'h0, 12'h0, 12'h0, 2'h2);
      wait_clk(4);
      check("immediate run", {scan_armed, rc[2:0]}, 4'h4);
      results();
   end
endmodule : relay_scan_command_control_tb
